// >>> fpc_cfg_regs.vh
/*
  constants for the floppy and parallel port configuration register bank:
  logical device numbers, register indexes, field positions and reset values.
  assumes it is included once by the bank module through its bare name.
*/
// Notes on behaviour
// - registers reset only on power-on or bus reset; soft reset leaves them alone
// - floppy registers live in logical device 0x00, parallel port in 0x03
// - floppy mode bit 0 picks normal or enhanced floppy mode
// - floppy mode bit 1: 0 burst DMA, 1 single transfers (reset)
// - floppy mode bits 3:2 pick host interface personality, 11 default
// - floppy mode bit 4 swaps drive select and motor lines of drives 0 and 1
// - floppy mode bit 6: 0 open-drain outputs, 1 push-pull
// - floppy mode bit 7 tri-states every floppy output
// - write protect from forced bit with selected drive, drive input, or disable bit
// - option bits 3:2 force density high (10) or low (11)
// - drive type store keeps A in 1:0, B in 3:2, resets to 0xff
// - floppy index 0xf3 reads zero and ignores writes
// - drive 0 parameters: type 1:0, rate table 4:3, precomp off bit 6
// - precomp disable bit set means that drive writes without precompensation
// - drive 1 parameters at 0xf5 mirror drive 0 layout and reset
// - parallel mode bits 2:0 select port mode, printer 100 by default
// - parallel mode bits 6:3 hold ECP FIFO threshold, reset 0111
// - parallel mode bit 7 set gives pulsed low interrupt then release
// - bit 7 clear: irq follows acknowledge or is level; ignored in printer/SPP
// - second parallel mode bit 4 picks how the EPP timeout flag clears
// - host uses index port and data port at next address, base by strap
`ifndef FPC_CFG_REGS_VH
`define FPC_CFG_REGS_VH

`define FPC_LDN_FLOPPY      8'h00
`define FPC_LDN_PARPORT     8'h03
`define FPC_IDX_LDN         8'h07
`define FPC_IDX_F0          8'hf0
`define FPC_IDX_F1          8'hf1
`define FPC_IDX_F2          8'hf2
`define FPC_IDX_F3          8'hf3
`define FPC_IDX_F4          8'hf4
`define FPC_IDX_F5          8'hf5

`define FPC_CFG_BASE_LO     16'h002e
`define FPC_CFG_BASE_HI     16'h004e
`define FPC_PORT_STEP       16'h0001

`define FPC_IDX_RST         8'h00
`define FPC_READ_ZERO       8'h00

`define FPC_FMODE_RST       8'h0e
`define FPC_FMODE_MASK      8'hdf
`define FPC_FOPT_RST        8'h00
`define FPC_FOPT_MASK       8'h0d
`define FPC_FTYPE_RST       8'hff
`define FPC_DRV_RST         8'h00
`define FPC_DRV_MASK        8'h5b
`define FPC_PMODE_RST       8'h3c
`define FPC_PMODE2_RST      8'h00
`define FPC_PMODE2_MASK     8'h10

`define FPC_DENS_HIGH       2'b10
`define FPC_DENS_LOW        2'b11
`define FPC_PP_PRINTER      3'b100
`define FPC_PP_SPP          3'b000

`endif

// >>> fpc_cfg_bank.v
/*
  configuration register bank for the floppy controller and parallel port
  logical devices, reached through an index/data port pair on a byte-wide
  io strobe interface. assumes io_wr/io_rd are one-cycle strobes synchronous
  to core_clk and that the floppy and parallel cores sit outside.
*/
`timescale 1ns/1ps
`include "fpc_cfg_regs.vh"

module fpc_cfg_bank (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        config_port_strap,
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  output wire        io_hit,
  // floppy side
  input  wire        drive_select_n_0,
  input  wire        drive_select_n_1,
  input  wire        motor_on_n_0,
  input  wire        motor_on_n_1,
  input  wire        write_protect_n,
  input  wire        floppy_wp_disable,
  input  wire        density_core,
  output wire        core_write_protect_n,
  output wire        drive_select_n_0_o,
  output wire        drive_select_n_0_oe,
  output wire        drive_select_n_1_o,
  output wire        drive_select_n_1_oe,
  output wire        motor_on_n_0_o,
  output wire        motor_on_n_0_oe,
  output wire        motor_on_n_1_o,
  output wire        motor_on_n_1_oe,
  output wire        density_o,
  output wire        density_oe,
  output wire        floppy_enhanced,
  output wire        floppy_single_dma,
  output wire [1:0]  floppy_if_mode,
  output wire [1:0]  drive_a_type,
  output wire [1:0]  drive_b_type,
  output wire [1:0]  drive_type_sel_0,
  output wire [1:0]  drive_type_sel_1,
  output wire [1:0]  data_rate_table_0,
  output wire [1:0]  data_rate_table_1,
  output wire        precomp_enable_0,
  output wire        precomp_enable_1,
  // parallel side
  input  wire        pp_ack_n,
  input  wire        pp_level_irq,
  input  wire        pp_irq_event,
  output wire [2:0]  pp_mode,
  output wire [3:0]  pp_fifo_threshold,
  output wire        pp_timeout_clr_on_read,
  output wire        pp_irq_o,
  output wire        pp_irq_oe
);

  // ==========================================================
  // port decode
  // ==========================================================
  reg  [15:0] base_q;
  reg         base_init_q;
  reg  [7:0]  index_q;
  reg  [7:0]  ldn_q;
  reg  [7:0]  fmode_q;
  reg  [7:0]  fopt_q;
  reg  [7:0]  ftype_q;
  reg  [7:0]  drv0_q;
  reg  [7:0]  drv1_q;
  reg  [7:0]  pmode_q;
  reg  [7:0]  pmode2_q;
  reg         pulse_q;

  wire idx_sel  = (io_addr == base_q);
  wire data_sel = (io_addr == base_q + `FPC_PORT_STEP);
  wire is_fdd   = (ldn_q == `FPC_LDN_FLOPPY);
  wire is_pp    = (ldn_q == `FPC_LDN_PARPORT);
  wire dwr      = io_wr & data_sel;

  assign io_hit = idx_sel | data_sel;

  // strap is caught by a clocked process after reset release, not by the reset itself
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      base_q      <= `FPC_CFG_BASE_LO;
      base_init_q <= 1'b0;
    end else if (!base_init_q) begin
      base_q      <= config_port_strap ? `FPC_CFG_BASE_HI : `FPC_CFG_BASE_LO;
      base_init_q <= 1'b1;
    end
  end

  // ==========================================================
  // registers
  // ==========================================================
  // ==========================================================
  // write decode
  // ==========================================================
  // one strobe per register; index 0xf3 and unknown indexes get none, so those writes vanish
  wire wr_index  = io_wr & idx_sel;
  wire wr_ldn    = dwr & (index_q == `FPC_IDX_LDN);
  wire wr_fmode  = dwr & is_fdd & (index_q == `FPC_IDX_F0);
  wire wr_fopt   = dwr & is_fdd & (index_q == `FPC_IDX_F1);
  wire wr_ftype  = dwr & is_fdd & (index_q == `FPC_IDX_F2);
  wire wr_drv0   = dwr & is_fdd & (index_q == `FPC_IDX_F4);
  wire wr_drv1   = dwr & is_fdd & (index_q == `FPC_IDX_F5);
  wire wr_pmode  = dwr & is_pp & (index_q == `FPC_IDX_F0);
  wire wr_pmode2 = dwr & is_pp & (index_q == `FPC_IDX_F1);

  reg  [7:0]  index_d;
  reg  [7:0]  ldn_d;
  reg  [7:0]  fmode_d;
  reg  [7:0]  fopt_d;
  reg  [7:0]  ftype_d;
  reg  [7:0]  drv0_d;
  reg  [7:0]  drv1_d;
  reg  [7:0]  pmode_d;
  reg  [7:0]  pmode2_d;

  // reserved bits are masked on the way in, so they always read back as zero
  always @* begin
    index_d  = index_q;
    ldn_d    = ldn_q;
    fmode_d  = fmode_q;
    fopt_d   = fopt_q;
    ftype_d  = ftype_q;
    drv0_d   = drv0_q;
    drv1_d   = drv1_q;
    pmode_d  = pmode_q;
    pmode2_d = pmode2_q;
    if (wr_index)
      index_d = io_wdata;
    if (wr_ldn)
      ldn_d = io_wdata;
    if (wr_fmode)
      fmode_d = io_wdata & `FPC_FMODE_MASK;
    if (wr_fopt)
      fopt_d = io_wdata & `FPC_FOPT_MASK;
    if (wr_ftype)
      ftype_d = io_wdata;
    if (wr_drv0)
      drv0_d = io_wdata & `FPC_DRV_MASK;
    if (wr_drv1)
      drv1_d = io_wdata & `FPC_DRV_MASK;
    if (wr_pmode)
      pmode_d = io_wdata;
    if (wr_pmode2)
      pmode2_d = io_wdata & `FPC_PMODE2_MASK;
  end

  // nrst is the hard reset (power-on or bus reset); there is no soft reset input
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      index_q  <= `FPC_IDX_RST;
      ldn_q    <= `FPC_LDN_FLOPPY;
      fmode_q  <= `FPC_FMODE_RST;
      fopt_q   <= `FPC_FOPT_RST;
      ftype_q  <= `FPC_FTYPE_RST;
      drv0_q   <= `FPC_DRV_RST;
      drv1_q   <= `FPC_DRV_RST;
      pmode_q  <= `FPC_PMODE_RST;
      pmode2_q <= `FPC_PMODE2_RST;
    end else begin
      index_q  <= index_d;
      ldn_q    <= ldn_d;
      fmode_q  <= fmode_d;
      fopt_q   <= fopt_d;
      ftype_q  <= ftype_d;
      drv0_q   <= drv0_d;
      drv1_q   <= drv1_d;
      pmode_q  <= pmode_d;
      pmode2_q <= pmode2_d;
    end
  end

  // ==========================================================
  // read back
  // ==========================================================
  reg  [7:0]  rdata_d;

  always @* begin
    rdata_d = `FPC_READ_ZERO;
    if (idx_sel)
      rdata_d = index_q;
    else if (data_sel && index_q == `FPC_IDX_LDN)
      rdata_d = ldn_q;
    else if (data_sel && is_fdd) begin
      case (index_q)
        `FPC_IDX_F0: rdata_d = fmode_q;
        `FPC_IDX_F1: rdata_d = fopt_q;
        `FPC_IDX_F2: rdata_d = ftype_q;
        `FPC_IDX_F4: rdata_d = drv0_q;
        `FPC_IDX_F5: rdata_d = drv1_q;
        default:     rdata_d = `FPC_READ_ZERO;
      endcase
    end else if (data_sel && is_pp) begin
      case (index_q)
        `FPC_IDX_F0: rdata_d = pmode_q;
        `FPC_IDX_F1: rdata_d = pmode2_q;
        default:     rdata_d = `FPC_READ_ZERO;
      endcase
    end
  end

  // read data is registered and held until the next read strobe
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      io_rdata <= `FPC_READ_ZERO;
    else if (io_rd)
      io_rdata <= rdata_d;
  end

  // ==========================================================
  // floppy controls
  // ==========================================================
  // all fields are wired straight out so a write takes hold next cycle
  assign floppy_enhanced   = fmode_q[0];
  assign floppy_single_dma = fmode_q[1];
  assign floppy_if_mode    = fmode_q[3:2];
  assign drive_a_type      = ftype_q[1:0];
  assign drive_b_type      = ftype_q[3:2];
  assign drive_type_sel_0  = drv0_q[1:0];
  assign drive_type_sel_1  = drv1_q[1:0];
  assign data_rate_table_0 = drv0_q[4:3];
  assign data_rate_table_1 = drv1_q[4:3];
  assign precomp_enable_0  = ~drv0_q[6];
  assign precomp_enable_1  = ~drv1_q[6];

  wire swap  = fmode_q[4];
  wire ppull = fmode_q[6];
  wire tri_s = fmode_q[7];

  wire ds0 = swap ? drive_select_n_1 : drive_select_n_0;
  wire ds1 = swap ? drive_select_n_0 : drive_select_n_1;
  wire mt0 = swap ? motor_on_n_1 : motor_on_n_0;
  wire mt1 = swap ? motor_on_n_0 : motor_on_n_1;

  // open-drain drives only the low level; push-pull drives both
  function drv_oe;
    input lvl;
    input pp;
    input ts;
    begin
      drv_oe = ~ts & (pp | ~lvl);
    end
  endfunction

  // density: forced levels override the core, else core level passes
  wire dens = (fopt_q[3:2] == `FPC_DENS_HIGH) ? 1'b1 :
              (fopt_q[3:2] == `FPC_DENS_LOW)  ? 1'b0 : density_core;

  assign drive_select_n_0_o  = ds0;
  assign drive_select_n_1_o  = ds1;
  assign motor_on_n_0_o      = mt0;
  assign motor_on_n_1_o      = mt1;
  assign density_o           = dens;
  assign drive_select_n_0_oe = drv_oe(ds0, ppull, tri_s);
  assign drive_select_n_1_oe = drv_oe(ds1, ppull, tri_s);
  assign motor_on_n_0_oe     = drv_oe(mt0, ppull, tri_s);
  assign motor_on_n_1_oe     = drv_oe(mt1, ppull, tri_s);
  assign density_oe          = drv_oe(dens, ppull, tri_s);

  // active-low protect: asserted when a selected drive is forced, input low, or disabled
  wire wp_act = (~drive_select_n_0 & fopt_q[0]) | (~drive_select_n_1 & fopt_q[0]) |
                ~write_protect_n | floppy_wp_disable;
  assign core_write_protect_n = ~wp_act;

  // ==========================================================
  // parallel controls
  // ==========================================================
  assign pp_mode                = pmode_q[2:0];
  assign pp_fifo_threshold      = pmode_q[6:3];
  assign pp_timeout_clr_on_read = pmode2_q[4];

  wire pp_basic = (pmode_q[2:0] == `FPC_PP_PRINTER) | (pmode_q[2:0] == `FPC_PP_SPP);
  wire pulsed   = pmode_q[7] & ~pp_basic;

  // one-cycle low pulse per event, then the line is released
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      pulse_q <= 1'b0;
    else
      pulse_q <= pulsed & pp_irq_event;
  end

  // follow mode is high on a low acknowledge or the core's level, in every port mode
  wire follow = pp_level_irq | ~pp_ack_n;
  assign pp_irq_o  = pulsed ? 1'b0 : follow;
  assign pp_irq_oe = pulsed ? pulse_q : 1'b1;

endmodule // fpc_cfg_bank

// >>> fpc_cfg_asserts.sv
/* port checker for the floppy/parallel configuration bank.
   assumes one clock domain and the async active-low reset nrst. */
`timescale 1ns/1ps
// ==========================================================
// checker
module fpc_cfg_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       io_rd,
  input wire logic       io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic       write_protect_n,
  input wire logic       floppy_wp_disable,
  input wire logic       drive_select_n_0,
  input wire logic       drive_select_n_1,
  input wire logic       core_write_protect_n,
  input wire logic       drive_select_n_0_o,
  input wire logic       drive_select_n_0_oe,
  input wire logic       drive_select_n_1_oe,
  input wire logic       motor_on_n_0_oe,
  input wire logic       pp_ack_n,
  input wire logic       pp_level_irq,
  input wire logic       pp_irq_o,
  input wire logic       pp_irq_oe,
  input wire logic [2:0] pp_mode,
  input wire logic [3:0] pp_fifo_threshold,
  input wire logic       floppy_single_dma,
  input wire logic [1:0] floppy_if_mode,
  input wire logic [1:0] drive_a_type,
  input wire logic       precomp_enable_0
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rst_fl;
    $rose(nrst) |-> floppy_single_dma && floppy_if_mode == 2'b11 && drive_a_type == 2'b11 && precomp_enable_0;
  endproperty
  a_rst_fl: assert property (p_rst_fl) else $error("floppy defaults wrong after reset");
  property p_rst_pp;
    $rose(nrst) |-> pp_mode == 3'b100 && pp_fifo_threshold == 4'h7;
  endproperty
  a_rst_pp: assert property (p_rst_pp) else $error("parallel defaults wrong after reset");
  property p_wp_force;
    !write_protect_n || floppy_wp_disable |-> !core_write_protect_n;
  endproperty
  a_wp_force: assert property (p_wp_force) else $error("write protect not passed on");
  property p_wp_idle;
    write_protect_n && !floppy_wp_disable && drive_select_n_0 && drive_select_n_1 |-> core_write_protect_n;
  endproperty
  a_wp_idle: assert property (p_wp_idle) else $error("write protect without cause");
  property p_push;
    drive_select_n_0_oe && drive_select_n_0_o |-> motor_on_n_0_oe && drive_select_n_1_oe;
  endproperty
  a_push: assert property (p_push) else $error("push-pull not applied to all outputs");
  property p_tri;
    !drive_select_n_0_oe && !drive_select_n_0_o |-> !motor_on_n_0_oe && !drive_select_n_1_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("tri-state not applied to all outputs");
  property p_irq_src;
    pp_irq_oe && pp_irq_o |-> pp_level_irq || !pp_ack_n;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq high without a source");
  property p_irq_rel;
    !pp_irq_oe |-> pp_mode != 3'b100 && pp_mode != 3'b000;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq released in printer or spp mode");
  property p_rdata;
    !$past(io_rd) |-> $stable(io_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  property p_cfg_hold;
    !$past(io_wr) |-> $stable(precomp_enable_0) && $stable(floppy_if_mode) && $stable(pp_mode);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config field moved without a write");
  c_pulse: cover property (!pp_irq_oe ##1 pp_irq_oe && !pp_irq_o ##1 !pp_irq_oe);
  c_wp: cover property (!drive_select_n_0 && !core_write_protect_n);
  c_tri: cover property (!drive_select_n_0_oe && !drive_select_n_0_o);
endmodule // fpc_cfg_chk

bind fpc_cfg_bank fpc_cfg_chk u_chk (.*);

// >>> fpc_host_model.sv
/* host model: drives the index/data port pair with one-cycle strobes.
   assumes the bank decodes the pair at BASE and BASE+1. */
`timescale 1ns/1ps
// ==========================================================
// host
module fpc_host_model #(parameter logic [15:0] BASE = 16'h002e) (
  input  wire logic [7:0]  io_rdata,
  input  wire logic        core_clk,
  output logic      [15:0] io_addr = BASE,
  output logic             io_wr = 1'b0,
  output logic             io_rd = 1'b0,
  output logic      [7:0]  io_wdata = 8'h00
);
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    put(BASE, idx);
    put(BASE + 16'h0001, d);
    @(posedge core_clk);
    io_wr    <= 1'b0;
    io_wdata <= ~d; // released bus must not echo the last byte
    @(posedge core_clk);
  endtask
  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] q);
    put(BASE, idx);
    @(posedge core_clk);
    io_wr   <= 1'b0;
    io_rd   <= 1'b1;
    io_addr <= BASE + 16'h0001;
    @(posedge core_clk);
    io_rd <= 1'b0;
    @(posedge core_clk);
    q = io_rdata;
  endtask
  // idle bus parked on an address, no strobe
  task automatic park(input logic [15:0] a);
    @(posedge core_clk);
    io_addr <= a;
  endtask
endmodule // fpc_host_model

// >>> testbench.sv
/* self-checking bench for the configuration bank.
   assumes a 100 MHz clock and strap low, so the port pair is at 0x2e. */
`timescale 1ns/1ps
// ==========================================================
// bench
module testbench;
  logic core_clk = 1'b0, nrst = 1'b0, config_port_strap = 1'b0, density_core = 1'b0;
  logic drive_select_n_0 = 1'b1, drive_select_n_1 = 1'b1, motor_on_n_0 = 1'b0, motor_on_n_1 = 1'b1;
  logic write_protect_n = 1'b1, floppy_wp_disable = 1'b0, pp_ack_n = 1'b1, pp_level_irq = 1'b0, pp_irq_event = 1'b0;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, q;
  logic io_wr, io_rd, io_hit, core_write_protect_n, density_o, density_oe, floppy_enhanced, floppy_single_dma;
  logic drive_select_n_0_o, drive_select_n_0_oe, drive_select_n_1_o, drive_select_n_1_oe, motor_on_n_0_o;
  logic motor_on_n_0_oe, motor_on_n_1_o, motor_on_n_1_oe, precomp_enable_0, precomp_enable_1;
  logic pp_timeout_clr_on_read, pp_irq_o, pp_irq_oe;
  logic [1:0] floppy_if_mode, drive_a_type, drive_b_type, drive_type_sel_0, drive_type_sel_1;
  logic [1:0] data_rate_table_0, data_rate_table_1;
  logic [2:0] pp_mode;
  logic [3:0] pp_fifo_threshold;
  int failures = 0, check_count = 0;
  localparam logic [7:0] FRST [6] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FMAX [6] = '{8'hdf, 8'h0d, 8'hff, 8'h00, 8'h5b, 8'h5b};
  localparam logic [2:0] MODES [7] = '{3'b100, 3'b000, 3'b001, 3'b101, 3'b010, 3'b011, 3'b111};
  wire [7:0] pins = {drive_select_n_0_o, drive_select_n_0_oe, drive_select_n_1_o, drive_select_n_1_oe,
                     motor_on_n_0_o, motor_on_n_0_oe, motor_on_n_1_o, motor_on_n_1_oe};
  fpc_cfg_bank dut (.*);
  fpc_host_model host (.io_rdata(io_rdata), .core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr),
                       .io_rd(io_rd), .io_wdata(io_wdata));
  always #5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    host.cfg_rd(idx, q);
    chk("register", e, q);
  endtask
  task automatic hard_reset(input logic strap);
    nrst              <= 1'b0;
    config_port_strap <= strap;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic irq_pulse(input logic [7:0] e1, input logic [7:0] e2);
    pp_irq_event <= 1'b1;
    @(posedge core_clk);
    pp_irq_event <= 1'b0;
    // looked at on the falling edge, clear of the edge that moves the pulse
    @(negedge core_clk);
    chk("irq after event", e1, {6'h00, pp_irq_o, pp_irq_oe});
    @(posedge core_clk);
    @(negedge core_clk);
    chk("irq later", e2, {6'h00, pp_irq_o, pp_irq_oe});
    @(posedge core_clk);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    host.cfg_wr(8'h07, 8'h00);
    for (int i = 0; i < 6; i++) rchk(8'hf0 + 8'(i), FRST[i]);
    for (int i = 0; i < 6; i++) host.cfg_wr(8'hf0 + 8'(i), 8'hff);
    for (int i = 0; i < 6; i++) rchk(8'hf0 + 8'(i), FMAX[i]);
    chk("floppy fields", 8'hff, {floppy_enhanced, floppy_single_dma, floppy_if_mode, drive_type_sel_0,
        data_rate_table_0});
    chk("second drive fields", 8'hff, {drive_a_type, drive_b_type, drive_type_sel_1, data_rate_table_1});
    drive_select_n_1 <= 1'b0;
    @(posedge core_clk);
    chk("precomp off", 8'h00, {6'h00, precomp_enable_0, precomp_enable_1});
    chk("tri-state", 8'h00, {3'b000, pins[7], pins[6], pins[4], pins[2], pins[0]});
    drive_select_n_1 <= 1'b1;
    $display("test floppy registers done");
    host.cfg_wr(8'h07, 8'h03);
    rchk(8'hf0, 8'h3c);
    rchk(8'hf1, 8'h00);
    host.cfg_wr(8'hf1, 8'hff);
    rchk(8'hf1, 8'h10);
    chk("timeout select", 8'h01, {7'h00, pp_timeout_clr_on_read});
    foreach (MODES[i]) begin
      host.cfg_wr(8'hf0, {1'b0, 4'h7, MODES[i]});
      chk("pp mode", {1'b0, MODES[i], 4'h7}, {1'b0, pp_mode, pp_fifo_threshold});
    end
    pp_ack_n <= 1'b0;
    @(posedge core_clk);
    chk("irq follows ack", 8'h03, {6'h00, pp_irq_o, pp_irq_oe});
    pp_ack_n     <= 1'b1;
    pp_level_irq <= 1'b1;
    @(posedge core_clk);
    chk("irq follows level", 8'h03, {6'h00, pp_irq_o, pp_irq_oe});
    pp_level_irq <= 1'b0;
    host.cfg_wr(8'hf0, 8'h82);
    irq_pulse(8'h01, 8'h00);
    host.cfg_wr(8'hf0, 8'h84);
    irq_pulse(8'h01, 8'h01);
    $display("test parallel port done");
    host.cfg_wr(8'h07, 8'h00);
    drive_select_n_0 <= 1'b0;
    host.cfg_wr(8'hf0, 8'h50);
    chk("swapped push-pull", 8'hdd, pins);
    host.cfg_wr(8'hf0, 8'h00);
    chk("open drain", 8'h66, pins);
    host.cfg_wr(8'hf1, 8'h01);
    chk("forced wp", 8'h00, {7'h00, core_write_protect_n});
    drive_select_n_0 <= 1'b1;
    @(posedge core_clk);
    chk("no drive selected", 8'h01, {7'h00, core_write_protect_n});
    write_protect_n <= 1'b0;
    @(posedge core_clk);
    chk("drive wp", 8'h00, {7'h00, core_write_protect_n});
    write_protect_n   <= 1'b1;
    floppy_wp_disable <= 1'b1;
    @(posedge core_clk);
    chk("disable wp", 8'h00, {7'h00, core_write_protect_n});
    floppy_wp_disable <= 1'b0;
    host.cfg_wr(8'hf0, 8'h40);
    host.cfg_wr(8'hf1, 8'h08);
    chk("density high", 8'h03, {6'h00, density_o, density_oe});
    host.cfg_wr(8'hf1, 8'h0c);
    chk("density low", 8'h01, {6'h00, density_o, density_oe});
    density_core <= 1'b1;
    host.cfg_wr(8'hf1, 8'h04);
    chk("density normal", 8'h03, {6'h00, density_o, density_oe});
    density_core <= 1'b0;
    $display("test floppy pins done");
    hard_reset(1'b1);
    host.park(16'h004f);
    @(posedge core_clk);
    chk("strap high data port", 8'h01, {7'h00, io_hit});
    host.park(16'h002e);
    @(posedge core_clk);
    chk("strap high old port", 8'h00, {7'h00, io_hit});
    hard_reset(1'b0);
    rchk(8'hf0, 8'h0e);
    rchk(8'hf1, 8'h00);
    host.cfg_wr(8'h07, 8'h03);
    rchk(8'hf0, 8'h3c);
    $display("test hard reset done");
    give_verdict();
  end
  initial begin
    #200us;
    failures++;
    give_verdict();
  end
endmodule // testbench
